// *** logic/dct_regs.sv ***
// APB register bank for converter code, trim codes and operation command
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R01: Code write replaces active code at once
// R02: Ten-bit code lives in bits 11-2
// R03: Eight-bit mode ignores two lowest field bits
// R04: Upper trim register at 25h, resets zero
// R05: Lower trim register at 26h, resets zero
// R06: Operation register at 01h, byte 15-8
// R07: Command 00h turns off, 80h on
// R08: Command A4h drives to upper trim
// R09: Command 94h drives to lower trim
// R10: Trim flag clears when code reaches target
// R11: Bad value sets fault bit 9, W1C
// R12: Turn-on resumes stored code; others ignored
module dct_regs (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic [9:0]       dac_code,
  output logic             dac_enable,
  output logic             irq
);
  logic        rst_meta_reg;
  logic        rst_n_reg;
  logic [7:0]  op_cmd_reg;
  logic [9:0]  code_reg;
  logic [9:0]  hi_reg;
  logic [9:0]  lo_reg;
  logic        mode8_reg;
  logic        hi_flag_reg;
  logic        lo_flag_reg;
  logic [2:0]  stat_reg;
  logic [2:0]  mask_reg;
  logic [2:0]  stat_next;
  logic [2:0]  events;
  logic        hit_op;
  logic        hit_code;
  logic        hit_hi;
  logic        hit_lo;
  logic        hit_status;
  logic        hit_istat;
  logic        hit_imask;
  logic        hit_config;
  logic        hit_flags;
  logic        addr_ok;
  logic        access;
  logic        wr;
  logic [15:0] rd_word;
  logic [15:0] wdat;
  logic [9:0]  wfield;
  logic [7:0]  wcmd;
  logic        cmd_take;
  logic        cmd_bad;
  logic        take_on;
  logic        take_hi;
  logic        take_lo;
  logic        code_wr;
  logic        ramp_load;
  logic [9:0]  ramp_val;
  logic        ramp_start;
  logic [9:0]  ramp_target;
  logic        ramp_busy;
  logic        ramp_reached;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Address decode
  assign hit_op     = (paddr == dct_pkg::ADDR_OP);
  assign hit_code   = (paddr == dct_pkg::ADDR_CODE);
  assign hit_hi     = (paddr == dct_pkg::ADDR_HI);
  assign hit_lo     = (paddr == dct_pkg::ADDR_LO);
  assign hit_status = (paddr == dct_pkg::ADDR_STATUS);
  assign hit_istat  = (paddr == dct_pkg::ADDR_IRQ_STAT);
  assign hit_imask  = (paddr == dct_pkg::ADDR_IRQ_MASK);
  assign hit_config = (paddr == dct_pkg::ADDR_CONFIG);
  assign hit_flags  = (paddr == dct_pkg::ADDR_FLAGS);
  assign addr_ok    = hit_op | hit_code | hit_hi | hit_lo | hit_status
                    | hit_istat | hit_imask | hit_config | hit_flags;

  // Access phase completes on the cycle pready is high
  assign access = psel & penable & pready;
  assign wr     = access & pwrite & addr_ok;

  // Read multiplexer, also the base for partial writes
  always_comb begin
    rd_word = 16'h0000;
    if (hit_op) begin
      rd_word = {op_cmd_reg, 8'h00}; // R06
    end else if (hit_code) begin
      rd_word = {4'h0, code_reg, 2'b00}; // R02
    end else if (hit_hi) begin
      rd_word = {4'h0, hi_reg, 2'b00}; // R04
    end else if (hit_lo) begin
      rd_word = {4'h0, lo_reg, 2'b00}; // R05
    end else if (hit_status) begin
      rd_word[dct_pkg::FAULT_BIT] = stat_reg[dct_pkg::IRQ_FAULT];
    end else if (hit_istat) begin
      rd_word = {13'h0000, stat_reg};
    end else if (hit_imask) begin
      rd_word = {13'h0000, mask_reg};
    end else if (hit_config) begin
      rd_word = {15'h0000, mode8_reg};
    end else if (hit_flags) begin
      rd_word[dct_pkg::FLAG_HI_BIT] = hi_flag_reg;
      rd_word[dct_pkg::FLAG_LO_BIT] = lo_flag_reg;
    end
  end

  // Byte-lane merge of write data
  assign wdat[15:8] = pstrb[1] ? pwdata[15:8] : rd_word[15:8];
  assign wdat[7:0]  = pstrb[0] ? pwdata[7:0] : rd_word[7:0];
  assign wcmd       = wdat[dct_pkg::CMD_MSB:dct_pkg::CMD_LSB];

  // Code field, low bits dropped in eight-bit mode
  assign wfield = mode8_reg
                ? (wdat[dct_pkg::CODE_MSB:dct_pkg::CODE_LSB] & dct_pkg::CODE_MASK8) // R03
                : wdat[dct_pkg::CODE_MSB:dct_pkg::CODE_LSB]; // R02

  // Command decode
  assign cmd_take = wr & hit_op & pstrb[1];
  assign cmd_bad  = cmd_take & (wcmd != dct_pkg::CMD_OFF) & (wcmd != dct_pkg::CMD_ON)
                  & (wcmd != dct_pkg::CMD_TRIM_HI) & (wcmd != dct_pkg::CMD_TRIM_LO); // R11
  assign take_on  = cmd_take & (wcmd == dct_pkg::CMD_ON);
  assign take_hi  = cmd_take & (wcmd == dct_pkg::CMD_TRIM_HI);
  assign take_lo  = cmd_take & (wcmd == dct_pkg::CMD_TRIM_LO);
  assign code_wr  = wr & hit_code & (pstrb[1:0] != 2'b00);

  // Ramp control: code write or turn-on loads, trim commands start a move
  assign ramp_load   = code_wr | take_on; // R01 R12
  assign ramp_val    = code_wr ? wfield : code_reg; // R01 R12
  assign ramp_start  = take_hi | take_lo; // R08 R09
  assign ramp_target = take_hi ? hi_reg : lo_reg; // R08 R09

  dct_ramp u_ramp (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n_reg),
    .load     (ramp_load),
    .load_val (ramp_val),
    .start    (ramp_start),
    .target   (ramp_target),
    .code     (dac_code),
    .busy     (ramp_busy),
    .reached  (ramp_reached)
  );

  // APB answer: one wait-free access phase, registered
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel && !penable && !pwrite) begin
        prdata <= {16'h0000, rd_word};
      end
    end
  end

  // Data registers
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      code_reg <= dct_pkg::CODE_RESET;
      hi_reg   <= dct_pkg::CODE_RESET; // R04
      lo_reg   <= dct_pkg::CODE_RESET; // R05
    end else if (wr) begin
      if (hit_code) begin
        code_reg <= wfield; // R02
      end
      if (hit_hi) begin
        hi_reg <= wfield; // R04
      end
      if (hit_lo) begin
        lo_reg <= wfield; // R05
      end
    end
  end

  // Operation command byte and variant select
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      op_cmd_reg <= dct_pkg::CMD_RESET;
      mode8_reg  <= 1'b0;
    end else begin
      if (cmd_take) begin
        op_cmd_reg <= wcmd; // R06
      end
      if (wr && hit_config && pstrb[0]) begin
        mode8_reg <= pwdata[0];
      end
    end
  end

  // Output enable follows the command; unknown values leave it alone
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      dac_enable <= 1'b0;
    end else if (cmd_take) begin
      if (wcmd == dct_pkg::CMD_OFF) begin
        dac_enable <= 1'b0; // R07
      end else if (take_on || take_hi || take_lo) begin
        dac_enable <= 1'b1; // R07 R12
      end
    end
  end

  // Trim move flags, cleared on arrival or a new code
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hi_flag_reg <= 1'b0;
      lo_flag_reg <= 1'b0;
    end else if (code_wr || take_on || (cmd_take && wcmd == dct_pkg::CMD_OFF)) begin
      hi_flag_reg <= 1'b0;
      lo_flag_reg <= 1'b0;
    end else if (take_hi) begin
      hi_flag_reg <= 1'b1; // R08
      lo_flag_reg <= 1'b0;
    end else if (take_lo) begin
      lo_flag_reg <= 1'b1; // R09
      hi_flag_reg <= 1'b0;
    end else if (ramp_reached) begin
      hi_flag_reg <= 1'b0; // R10
      lo_flag_reg <= 1'b0;
    end
  end

  // Event sources
  assign events[dct_pkg::IRQ_FAULT]   = cmd_bad | (access & pwrite & ~addr_ok); // R11
  assign events[dct_pkg::IRQ_HI_DONE] = ramp_reached & hi_flag_reg & ~ramp_start & ~ramp_load;
  assign events[dct_pkg::IRQ_LO_DONE] = ramp_reached & lo_flag_reg & ~ramp_start & ~ramp_load;

  // Sticky status: write one clears, a new event wins
  always_comb begin
    stat_next = stat_reg;
    if (wr && hit_istat && pstrb[0]) begin
      stat_next = stat_next & ~pwdata[2:0];
    end
    if (wr && hit_status && pstrb[1] && pwdata[dct_pkg::FAULT_BIT]) begin
      stat_next[dct_pkg::IRQ_FAULT] = 1'b0; // R11
    end
    stat_next = stat_next | events; // R11
  end

  // Status, mask and interrupt line
  always_ff @(posedge sys_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      stat_reg <= dct_pkg::IRQ_RESET;
      mask_reg <= dct_pkg::IRQ_RESET;
      irq      <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr && hit_imask && pstrb[0]) begin
        mask_reg <= pwdata[2:0];
      end
      irq <= |(stat_reg & mask_reg);
    end
  end

  // Checks
  chk_code_write_load: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R01
    code_wr |=> dac_code == $past(wfield))
    else $error("code write did not reach active code");

  chk_field_align: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R02
    (wr && hit_hi && pstrb == 4'hF && !mode8_reg)
      |=> hi_reg == $past(pwdata[11:2]))
    else $error("upper trim field misaligned");

  chk_mode8_drop: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R03
    (code_wr && mode8_reg) |=> dac_code[1:0] == 2'b00)
    else $error("eight-bit code kept low bits");

  chk_lo_readback: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R05
    (wr && hit_lo && pstrb == 4'hF && !mode8_reg)
      |=> lo_reg == $past(pwdata[11:2]) ##1 !$changed(lo_reg) || $past(wr))
    else $error("lower trim write lost");

  chk_op_store: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R06
    (cmd_take && pstrb[1]) |=> op_cmd_reg == $past(pwdata[15:8]))
    else $error("command byte not stored");

  chk_off_cmd: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R07
    (cmd_take && wcmd == dct_pkg::CMD_OFF) |=> !dac_enable)
    else $error("off command left output on");

  chk_on_resume: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R12
    take_on |=> dac_enable && dac_code == $past(code_reg))
    else $error("turn-on did not resume stored code");

  chk_hi_move: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R08
    take_hi |=> hi_flag_reg && !lo_flag_reg && ramp_busy)
    else $error("upper trim move not started");

  chk_lo_move: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R09
    take_lo |=> lo_flag_reg && !hi_flag_reg && ramp_busy)
    else $error("lower trim move not started");

  // Any command or code write may cancel a move, so only arrivals count
  chk_hi_arrive: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R10
    $fell(hi_flag_reg) && !$past(ramp_load) && !$past(ramp_start) && !$past(cmd_take)
      |-> dac_code == hi_reg)
    else $error("upper flag cleared before arrival");

  chk_lo_arrive: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R10
    $fell(lo_flag_reg) && !$past(ramp_load) && !$past(cmd_take)
      |-> dac_code == lo_reg)
    else $error("lower flag cleared before arrival");

  chk_trim_enable: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R08 R09
    (take_hi || take_lo) |=> dac_enable)
    else $error("trim command left output off");

  chk_fault_set: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R11
    cmd_bad |=> stat_reg[0] ##1 irq || !mask_reg[0])
    else $error("bad command did not raise fault");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R11
    (stat_reg[dct_pkg::IRQ_FAULT] && mask_reg[dct_pkg::IRQ_FAULT]) |=> irq)
    else $error("unmasked fault did not raise interrupt");

  chk_fault_clear: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R11
    (wr && hit_status && pstrb[1] && pwdata[dct_pkg::FAULT_BIT]
      && !events[dct_pkg::IRQ_FAULT]) |=> !stat_reg[dct_pkg::IRQ_FAULT])
    else $error("fault flag not cleared by one");

  chk_bad_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n_reg) // R12
    cmd_bad |=> $stable(dac_enable) && $stable(dac_code))
    else $error("unknown command changed output");
endmodule
`default_nettype wire

// *** shared/dct_pkg.sv ***
// Constants shared by the converter code and trim register bank
package dct_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_OP        = 10'h001;
  localparam logic [9:0]  IDX_CODE      = 10'h021;
  localparam logic [9:0]  IDX_HI        = 10'h025;
  localparam logic [9:0]  IDX_LO        = 10'h026;
  localparam logic [9:0]  IDX_STATUS    = 10'h078;
  localparam logic [9:0]  IDX_IRQ_STAT  = 10'h080;
  localparam logic [9:0]  IDX_IRQ_MASK  = 10'h081;
  localparam logic [9:0]  IDX_CONFIG    = 10'h082;
  localparam logic [9:0]  IDX_FLAGS     = 10'h0D3;
  localparam logic [11:0] ADDR_OP       = {IDX_OP, 2'b00};
  localparam logic [11:0] ADDR_CODE     = {IDX_CODE, 2'b00};
  localparam logic [11:0] ADDR_HI       = {IDX_HI, 2'b00};
  localparam logic [11:0] ADDR_LO       = {IDX_LO, 2'b00};
  localparam logic [11:0] ADDR_STATUS   = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] ADDR_CONFIG   = {IDX_CONFIG, 2'b00};
  localparam logic [11:0] ADDR_FLAGS    = {IDX_FLAGS, 2'b00};
  // Code field bits 11-2, command byte bits 15-8
  localparam int          CODE_LSB      = 2;
  localparam int          CODE_MSB      = 11;
  localparam int          CMD_LSB       = 8;
  localparam int          CMD_MSB       = 15;
  localparam int          FAULT_BIT     = 9;
  localparam int          FLAG_HI_BIT   = 7;
  localparam int          FLAG_LO_BIT   = 6;
  localparam logic [9:0]  CODE_MASK8    = 10'h3FC;
  // Reset values
  localparam logic [9:0]  CODE_RESET    = 10'h000;
  localparam logic [7:0]  CMD_RESET     = 8'h00;
  localparam logic [2:0]  IRQ_RESET     = 3'h0;
  // Operation commands
  localparam logic [7:0]  CMD_OFF       = 8'h00;
  localparam logic [7:0]  CMD_ON        = 8'h80;
  localparam logic [7:0]  CMD_TRIM_HI   = 8'hA4;
  localparam logic [7:0]  CMD_TRIM_LO   = 8'h94;
  // Interrupt status bit positions
  localparam int          IRQ_FAULT     = 0;
  localparam int          IRQ_HI_DONE   = 1;
  localparam int          IRQ_LO_DONE   = 2;
  // Ramp step interval
  localparam int          CLK_NS        = 20;
  localparam int          STEP_NS       = 1000;
  localparam int          STEP_CYC      = STEP_NS / CLK_NS;
  localparam logic [7:0]  STEP_LAST     = 8'(STEP_CYC - 1);
endpackage

// *** logic/dct_ramp.sv ***
// Active code holder that steps toward a trim target one LSB per interval
`timescale 1ns/100ps
`default_nettype none
module dct_ramp (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [9:0] load_val,
  input  wire logic       start,
  input  wire logic [9:0] target,
  output logic [9:0]      code,
  output logic            busy,
  output logic            reached
);
  logic [9:0] tgt_reg;
  logic [7:0] tick_reg;
  logic       tick;

  assign tick = (tick_reg == dct_pkg::STEP_LAST);

  // Step interval timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 8'h00;
    end else if (start || load || tick || !busy) begin
      tick_reg <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  // Code, target and completion pulse
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      code    <= dct_pkg::CODE_RESET;
      tgt_reg <= dct_pkg::CODE_RESET;
      busy    <= 1'b0;
      reached <= 1'b0;
    end else begin
      reached <= 1'b0;
      if (load) begin
        code <= load_val;
        busy <= 1'b0;
      end else if (start) begin
        tgt_reg <= target;
        busy    <= 1'b1;
      end else if (busy) begin
        if (code == tgt_reg) begin
          busy    <= 1'b0;
          reached <= 1'b1;
        end else if (tick) begin
          code <= (code < tgt_reg) ? code + 10'h001 : code - 10'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** test/dct_apb_host.sv ***
// APB host model that issues register transfers into the bank
`timescale 1ns/100ps
`default_nettype none
module dct_apb_host (
  input  wire logic        sys_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
  end

  // One transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'hF;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;  // Released lines stop showing the old value
    pwdata  <= ~d;
    pstrb   <= 4'h0;
  endtask
endmodule
`default_nettype wire

// *** test/dac_code_and_trim_registers_tb.sv ***
// Self-checking bench for the converter code and trim register bank
`timescale 1ns/100ps
`default_nettype none
module dac_code_and_trim_registers_tb;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } dct_row_t;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [9:0]  dac_code;
  logic        dac_enable;
  logic        irq;
  logic [31:0] rdat;
  logic        serr;
  int          errors = 0;
  int          checks = 0;
  // Write, then read back the masked value
  dct_row_t    rows [4] = '{
    '{dct_pkg::ADDR_HI,   32'h0000_FFFF, 32'h0000_0FFC},
    '{dct_pkg::ADDR_LO,   32'h0000_1235, 32'h0000_0234},
    '{dct_pkg::ADDR_CODE, 32'h0000_F00F, 32'h0000_000C},
    '{dct_pkg::ADDR_OP,   32'h0000_80FF, 32'h0000_8000}};
  logic [11:0] rst_addr [4] = '{dct_pkg::ADDR_OP, dct_pkg::ADDR_HI,
                                dct_pkg::ADDR_LO, dct_pkg::ADDR_CODE};

  dct_regs u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .dac_code(dac_code),
    .dac_enable(dac_enable), .irq(irq)
  );
  dct_apb_host u_host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr)
  );

  // Free-running 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Write, then let registered outputs settle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdat, serr);
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, a, 32'h0000_0000, rdat, serr);
    chk(name, rdat, exp);
  endtask
  // Bounded wait for the ramp to land
  task automatic wait_code(input logic [9:0] t);
    for (int i = 0; i < 400 && dac_code !== t; i++) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rst_addr[i]) rdc("reset value", rst_addr[i], 32'h0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdc("readback", rows[i].addr, rows[i].rexp);
    end
    chk("code", 32'(dac_code), 32'h0000_0003);
    wr(dct_pkg::ADDR_CODE, 32'h0000_0100);
    chk("code write", 32'(dac_code), 32'h0000_0040);
    wr(dct_pkg::ADDR_OP, 32'h0000_0000);
    chk("off", 32'(dac_enable), 32'h0000_0000);
    wr(dct_pkg::ADDR_OP, 32'h0000_8000);
    chk("on", 32'(dac_enable), 32'h0000_0001);
    chk("resume", 32'(dac_code), 32'h0000_0040);
    // Upper trim move with done event
    wr(dct_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    wr(dct_pkg::ADDR_HI, 32'h0000_010C);
    wr(dct_pkg::ADDR_OP, 32'h0000_A400);
    rdc("upper flag", dct_pkg::ADDR_FLAGS, 32'h0000_0080);
    wait_code(10'h043);
    chk("upper code", 32'(dac_code), 32'h0000_0043);
    rdc("upper flag clear", dct_pkg::ADDR_FLAGS, 32'h0000_0000);
    rdc("upper event", dct_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    chk("irq raised", 32'(irq), 32'h0000_0001);
    wr(dct_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    // Lower trim move
    wr(dct_pkg::ADDR_LO, 32'h0000_0104);
    wr(dct_pkg::ADDR_OP, 32'h0000_9400);
    rdc("lower flag", dct_pkg::ADDR_FLAGS, 32'h0000_0040);
    wait_code(10'h041);
    chk("lower code", 32'(dac_code), 32'h0000_0041);
    rdc("lower event", dct_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    wr(dct_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
    // Turn-on from a trim level goes back to the stored code
    wr(dct_pkg::ADDR_OP, 32'h0000_8000);
    chk("resume trim", 32'(dac_code), 32'h0000_0040);
    // Unsupported command, masked then unmasked
    wr(dct_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    wr(dct_pkg::ADDR_OP, 32'h0000_5500);
    chk("bad cmd code", 32'(dac_code), 32'h0000_0040);
    chk("bad cmd on", 32'(dac_enable), 32'h0000_0001);
    rdc("fault set", dct_pkg::ADDR_STATUS, 32'h0000_0200);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    wr(dct_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    chk("irq fault", 32'(irq), 32'h0000_0001);
    wr(dct_pkg::ADDR_STATUS, 32'h0000_0200);
    rdc("fault clear", dct_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("irq fault clear", 32'(irq), 32'h0000_0000);
    // Unmapped place
    u_host.xfer(1'b1, 12'hFF0, 32'h0000_FFFF, rdat, serr);
    chk("unmapped wr err", 32'(serr), 32'h0000_0001);
    rdc("unmapped read", 12'hFF0, 32'h0000_0000);
    chk("unmapped rd err", 32'(serr), 32'h0000_0001);
    rdc("unmapped fault", dct_pkg::ADDR_STATUS, 32'h0000_0200);
    wr(dct_pkg::ADDR_STATUS, 32'h0000_0200);
    // Eight-bit variant
    wr(dct_pkg::ADDR_CONFIG, 32'h0000_0001);
    wr(dct_pkg::ADDR_CODE, 32'h0000_0FFF);
    rdc("eight-bit read", dct_pkg::ADDR_CODE, 32'h0000_0FF0);
    chk("eight-bit code", 32'(dac_code), 32'h0000_03FC);
    // Second reset in mid-run
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("reset code", 32'(dac_code), 32'h0000_0000);
    chk("reset on", 32'(dac_enable), 32'h0000_0000);
    chk("reset irq", 32'(irq), 32'h0000_0000);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc("reset upper", dct_pkg::ADDR_HI, 32'h0000_0000);
    rdc("reset op", dct_pkg::ADDR_OP, 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
